/* File: rtl/dwd_pkg.sv */
/*
  Constants, write request carrier and state layout for the write word decoder.
  Assumes the write interface delivers one complete word per strobe.
*/
package dwd_pkg;

  // ************************************************************
  // Sizes
  // ************************************************************
  localparam int DWD_WORD_W = 14;
  localparam int DWD_ADDR_W = 8;
  localparam int DWD_NUM_GROUPS = 4;
  localparam int DWD_GROUP_REGS = 10;
  localparam int DWD_NUM_CH = 40;
  localparam int DWD_CHAN_W = 6;
  localparam int DWD_STEP_W = 7;

  // ************************************************************
  // Destination select codes (high bit, low bit)
  // ************************************************************
  localparam logic [1:0] DWD_SEL_CODE = 2'h3;
  localparam logic [1:0] DWD_SEL_OFFSET = 2'h2;
  localparam logic [1:0] DWD_SEL_GAIN = 2'h1;
  localparam logic [1:0] DWD_SEL_SPECIAL = 2'h0;

  // ************************************************************
  // Field positions and code values
  // ************************************************************
  localparam int DWD_GROUP_LSB = 4;
  localparam int DWD_DIR_BIT = 8;
  localparam int DWD_STEP_GAP_BIT = 7;
  localparam int DWD_UPPER_LSB = 9;
  localparam logic [DWD_WORD_W-1:0] DWD_FULL_SCALE = 14'h3fff;
  localparam logic [DWD_WORD_W-1:0] DWD_ZERO_SCALE = 14'h0000;
  localparam logic [DWD_WORD_W-1:0] DWD_SOFT_RESET_WORD = 14'h3fff;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [DWD_WORD_W-1:0] DWD_CODE_RST = 14'h0000;
  localparam logic [DWD_WORD_W-1:0] DWD_OFFSET_RST = 14'h2000;
  localparam logic [DWD_WORD_W-1:0] DWD_GAIN_RST = 14'h3fff;

  typedef struct packed {
    logic [1:0] dest_select;
    logic [DWD_ADDR_W-1:0] channel_address;
    logic [DWD_WORD_W-1:0] write_word_bits;
  } dwd_wr_req_t;

  typedef struct packed {
    logic [DWD_NUM_CH-1:0][DWD_WORD_W-1:0] code;
    logic [DWD_NUM_CH-1:0][DWD_WORD_W-1:0] offset;
    logic [DWD_NUM_CH-1:0][DWD_WORD_W-1:0] gain;
    logic grounded;
    logic soft_reset;
    logic [DWD_WORD_W-1:0] rd_code;
    logic [DWD_WORD_W-1:0] rd_offset;
    logic [DWD_WORD_W-1:0] rd_gain;
  } dwd_state_t;

  localparam dwd_state_t DWD_RESET_STATE = '{
    code: {DWD_NUM_CH{DWD_CODE_RST}},
    offset: {DWD_NUM_CH{DWD_OFFSET_RST}},
    gain: {DWD_NUM_CH{DWD_GAIN_RST}},
    grounded: 1'b1,
    soft_reset: 1'b0,
    rd_code: DWD_CODE_RST,
    rd_offset: DWD_OFFSET_RST,
    rd_gain: DWD_GAIN_RST
  };

endpackage : dwd_pkg

/* File: rtl/dwd_write_decode.sv */
/*
  Write word decoder of a 40 channel converter: routes each word to code,
  offset or gain registers of the addressed channels, or runs a special function.
  Assumes one synchronous write strobe per word from the surrounding interface.
*/
`timescale 1ns/1ns

// How it works
// R1: The two destination select bits route the 14-bit word to code, offset, gain or special function.
// R2: Select 11 stores the word as a straight binary channel code, zero meaning zero volts.
// R3: Select 10 stores the word as offset binary, midscale meaning no offset.
// R4: Select 01 stores the word as a gain factor, all ones meaning unity.
// R5: Select 00 with upper bits clear steps codes by the low seven bits, a zero step changing nothing.
// R6: Select 00 with all ones is a soft reset that sends the outputs to reference ground.
// R7: An 8-bit address comes with each write and can pick any single channel register.
// R8: Upper address bits are a group mask for groups A to D, each chosen group written alike.
// R9: Lower address bits pick register 0 to 9 per group; a zero mask writes all 40 channels.
// R10: In step mode direction bit one increments and zero decrements.
// R11: Stepping saturates at full scale or zero scale instead of wrapping.
// R12: A register index of 10 to 15 with a group selected changes nothing, unless the word is the soft reset word.
module dwd_write_decode
  import dwd_pkg::*;
(
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic wr_i,
  input wire logic dest_select_high_i,
  input wire logic dest_select_low_i,
  input wire logic [DWD_ADDR_W-1:0] channel_address_i,
  input wire logic [DWD_WORD_W-1:0] write_word_bits_i,
  input wire logic [DWD_CHAN_W-1:0] rd_chan_i,
  output logic [DWD_WORD_W-1:0] rd_code_o,
  output logic [DWD_WORD_W-1:0] rd_offset_o,
  output logic [DWD_WORD_W-1:0] rd_gain_o,
  output logic reference_ground_level_o,
  output logic soft_reset_o
);

  // ************************************************************
  // Helpers
  // ************************************************************
  function automatic logic chan_hit(input logic [DWD_ADDR_W-1:0] addr, input int grp, input int reg_idx);
    logic mask_none;
    mask_none = (addr[DWD_ADDR_W-1:DWD_GROUP_LSB] == 4'h0);
    // With a group selected, index 10..15 never matches, so such writes fall through untouched
    chan_hit = mask_none || (addr[DWD_GROUP_LSB + grp] && (addr[3:0] == 4'(reg_idx))); // see R8 R9 R12
  endfunction : chan_hit

  function automatic logic [DWD_WORD_W-1:0] step_code(input logic [DWD_WORD_W-1:0] code,
                                                     input logic [DWD_STEP_W-1:0] step,
                                                     input logic up);
    logic [DWD_WORD_W:0] sum;
    // Extra top bit of the sum flags a pass beyond full scale
    sum = {1'b0, code} + {8'h00, step};
    if (up) begin // see R10
      step_code = sum[DWD_WORD_W] ? DWD_FULL_SCALE : sum[DWD_WORD_W-1:0]; // see R11
    end else if (code < {7'h00, step}) begin
      step_code = DWD_ZERO_SCALE; // see R11
    end else begin
      step_code = code - {7'h00, step};
    end
  endfunction : step_code

  dwd_state_t s_r;
  dwd_state_t s_nxt;
  dwd_wr_req_t req;
  logic step_ok;

  assign req = '{dest_select: {dest_select_high_i, dest_select_low_i},
                 channel_address: channel_address_i,
                 write_word_bits: write_word_bits_i};
  // Bit 7 must be clear too; any other pattern is not a defined step
  assign step_ok = (req.write_word_bits[DWD_WORD_W-1:DWD_UPPER_LSB] == 5'h00) &&
                   !req.write_word_bits[DWD_STEP_GAP_BIT];

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    int ch;
    ch = 0;
    s_nxt = s_r;
    s_nxt.soft_reset = 1'b0;
    // Readback is one cycle late so the outputs come straight from flops
    if (rd_chan_i < 6'(DWD_NUM_CH)) begin // see R7
      s_nxt.rd_code = s_r.code[rd_chan_i];
      s_nxt.rd_offset = s_r.offset[rd_chan_i];
      s_nxt.rd_gain = s_r.gain[rd_chan_i];
    end else begin
      s_nxt.rd_code = '0;
      s_nxt.rd_offset = '0;
      s_nxt.rd_gain = '0;
    end
    if (wr_i) begin
      // Soft reset word wins over whatever the address selects
      if (req.dest_select == DWD_SEL_SPECIAL && req.write_word_bits == DWD_SOFT_RESET_WORD) begin
        s_nxt.code = DWD_RESET_STATE.code; // see R6
        s_nxt.offset = DWD_RESET_STATE.offset;
        s_nxt.gain = DWD_RESET_STATE.gain;
        s_nxt.grounded = 1'b1;
        s_nxt.soft_reset = 1'b1;
      end else begin
        for (int g = 0; g < DWD_NUM_GROUPS; g++) begin
          for (int r = 0; r < DWD_GROUP_REGS; r++) begin
            ch = g * DWD_GROUP_REGS + r;
            if (chan_hit(req.channel_address, g, r)) begin // see R7 R8 R9
              case (req.dest_select) // see R1
                DWD_SEL_CODE: begin
                  s_nxt.code[ch] = req.write_word_bits; // see R2
                  s_nxt.grounded = 1'b0;
                end
                DWD_SEL_OFFSET: begin
                  s_nxt.offset[ch] = req.write_word_bits; // see R3
                end
                DWD_SEL_GAIN: begin
                  s_nxt.gain[ch] = req.write_word_bits; // see R4
                end
                default: begin
                  if (step_ok) begin // see R5
                    s_nxt.code[ch] = step_code(s_r.code[ch], req.write_word_bits[DWD_STEP_W-1:0],
                                               req.write_word_bits[DWD_DIR_BIT]); // see R10 R11
                  end
                end
              endcase
            end
          end
        end
      end
    end
  end

  // Reset is synchronous, so the whole state struct reloads on an edge
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      s_r <= DWD_RESET_STATE;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign rd_code_o = s_r.rd_code;
  assign rd_offset_o = s_r.rd_offset;
  assign rd_gain_o = s_r.rd_gain;
  assign reference_ground_level_o = s_r.grounded;
  assign soft_reset_o = s_r.soft_reset;

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  logic is_wr_code;
  logic is_step;
  logic is_soft;
  assign is_soft = wr_i && req.dest_select == DWD_SEL_SPECIAL && req.write_word_bits == DWD_SOFT_RESET_WORD;
  assign is_wr_code = wr_i && req.dest_select == DWD_SEL_CODE;
  assign is_step = wr_i && req.dest_select == DWD_SEL_SPECIAL && step_ok;

  a_broadcast_code: assert property ( // see R2 R9
    is_wr_code && req.channel_address == 8'h0f |=>
      s_r.code[0] == $past(write_word_bits_i) && s_r.code[39] == $past(write_word_bits_i) && !reference_ground_level_o)
    else $error("broadcast code write missed a channel");
  a_group_mask: assert property ( // see R8
    is_wr_code && req.channel_address == 8'h23 |=>
      s_r.code[13] == $past(write_word_bits_i) && $stable(s_r.code[3]) && $stable(s_r.code[23]))
    else $error("group B write hit the wrong channels");
  a_offset_route: assert property ( // see R1 R3
    wr_i && req.dest_select == DWD_SEL_OFFSET && req.channel_address == 8'h14 |=>
      s_r.offset[4] == $past(write_word_bits_i) && $stable(s_r.code) && $stable(s_r.gain))
    else $error("offset write misrouted");
  a_gain_pair: assert property ( // see R4 R8
    wr_i && req.dest_select == DWD_SEL_GAIN && req.channel_address == 8'h99 |=>
      s_r.gain[9] == $past(write_word_bits_i) && s_r.gain[39] == $past(write_word_bits_i) && $stable(s_r.gain[19]))
    else $error("gain write to groups A and D wrong");
  a_bad_index: assert property ( // see R12
    wr_i && req.channel_address[7:4] != 4'h0 && req.channel_address[3:0] > 4'h9 &&
      req.write_word_bits != DWD_SOFT_RESET_WORD |=>
      $stable(s_r.code) && $stable(s_r.offset) && $stable(s_r.gain))
    else $error("write to index above 9 changed state");
  a_zero_step: assert property ( // see R5
    is_step && req.write_word_bits[DWD_STEP_W-1:0] == 7'h00 |=> $stable(s_r.code))
    else $error("zero step changed a code");
  a_inc_sat: assert property ( // see R10 R11
    is_step && req.channel_address == 8'h00 && write_word_bits_i[DWD_DIR_BIT] |=>
      s_r.code[0] == (({1'b0, $past(s_r.code[0])} + {8'h00, $past(write_word_bits_i[6:0])}) > 15'h3fff ?
                      DWD_FULL_SCALE : $past(s_r.code[0]) + {7'h00, $past(write_word_bits_i[6:0])}))
    else $error("increment wrong or wrapped");
  a_dec_floor: assert property ( // see R10 R11
    is_step && req.channel_address == 8'h00 && !write_word_bits_i[DWD_DIR_BIT] |=>
      s_r.code[0] <= $past(s_r.code[0]) && (s_r.code[0] == DWD_ZERO_SCALE ||
      s_r.code[0] + {7'h00, $past(write_word_bits_i[6:0])} == $past(s_r.code[0])))
    else $error("decrement wrong or wrapped");
  a_soft_reset: assert property ( // see R6
    wr_i && req.dest_select == DWD_SEL_SPECIAL && req.write_word_bits == DWD_SOFT_RESET_WORD |=>
      soft_reset_o && reference_ground_level_o && s_r.code[17] == DWD_CODE_RST ##1 !soft_reset_o)
    else $error("soft reset did not ground outputs");
  a_readback: assert property ( // see R7
    rd_chan_i < 6'(DWD_NUM_CH) |=> rd_code_o == $past(s_r.code[rd_chan_i]) &&
      rd_gain_o == $past(s_r.gain[rd_chan_i]))
    else $error("readback mismatch");

  // ************************************************************
  // Refused words, side effects and readback range
  // ************************************************************
  // Undefined special words must leave every register alone
  a_special_ignored: assert property ( // see R5
    wr_i && req.dest_select == DWD_SEL_SPECIAL && !step_ok && !is_soft |=>
      $stable(s_r.code) && $stable(s_r.offset) && $stable(s_r.gain))
    else $error("undefined special word changed state");
  a_code_only: assert property ( // see R1
    is_wr_code |=> $stable(s_r.offset) && $stable(s_r.gain))
    else $error("code write touched offset or gain");
  // Ground flag moves only on a code write or a soft reset
  a_ground_hold: assert property ( // see R6
    !is_wr_code && !is_soft |=> $stable(reference_ground_level_o))
    else $error("ground flag moved without cause");
  a_soft_restore: assert property ( // see R6
    is_soft |=> s_r.offset == {DWD_NUM_CH{DWD_OFFSET_RST}} && s_r.gain == {DWD_NUM_CH{DWD_GAIN_RST}})
    else $error("soft reset left offset or gain");
  a_step_group: assert property ( // see R8 R10
    is_step && req.channel_address == 8'h23 |=> $stable(s_r.code[3]) && $stable(s_r.code[23]))
    else $error("step hit channels outside its group");
  a_readback_zero: assert property ( // see R7
    rd_chan_i >= 6'(DWD_NUM_CH) |=> rd_code_o == 14'h0000 && rd_offset_o == 14'h0000 && rd_gain_o == 14'h0000)
    else $error("readback beyond channel 39 not zero");

  // ************************************************************
  // Scenario coverage
  // ************************************************************
  c_soft_reset: cover property (soft_reset_o ##1 is_wr_code);
  c_readback_range: cover property (rd_chan_i >= 6'(DWD_NUM_CH) ##1 rd_code_o == 14'h0000);
  c_inc_sat: cover property (is_step && write_word_bits_i[DWD_DIR_BIT] ##1 s_r.code[0] == DWD_FULL_SCALE);
  c_dec_zero: cover property (is_step && !write_word_bits_i[DWD_DIR_BIT] ##1 s_r.code[0] == DWD_ZERO_SCALE);
  c_group_all: cover property (is_wr_code && req.channel_address[7:4] == 4'hf);

endmodule : dwd_write_decode

/* File: verification/dwd_host.sv */
/*
  Host side model: issues one write word per strobe at the falling edge.
  Assumes the decoder samples its write port on rising edges of clk_i.
*/
`timescale 1ns/1ns
module dwd_host
  import dwd_pkg::*;
(
  input wire logic clk_i,
  output logic wr_o,
  output dwd_wr_req_t req_o
);
  initial begin
    wr_o = 1'b0;
    req_o = '0;
  end

  // Released bus shows the inverse, so a stale word can never pass
  task automatic send(input logic [1:0] sel, input logic [7:0] adr, input logic [13:0] w);
    @(negedge clk_i);
    wr_o = 1'b1;
    req_o = '{dest_select: sel, channel_address: adr, write_word_bits: w};
    @(negedge clk_i);
    wr_o = 1'b0;
    req_o = ~req_o;
  endtask : send
endmodule : dwd_host

/* File: verification/dwd_write_decode_bench.sv */
/*
  Self-checking bench for the write word decoder, writes through dwd_host.
  Assumes readback shows a channel one edge after rd_chan_i is presented.
*/
`timescale 1ns/1ns
module dwd_write_decode_bench
  import dwd_pkg::*;
;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [5:0] rd_chan = '0;
  logic wr;
  dwd_wr_req_t req;
  logic [13:0] code, offs, gain;
  logic gnd, srst;
  int fail_count = 0;
  int tests_run = 0;
  int pulses;

  always #20 clk = ~clk;

  dwd_host host_u (.clk_i(clk), .wr_o(wr), .req_o(req));
  dwd_write_decode dut_u (.clk_i(clk), .nrst_i(nrst), .wr_i(wr),
    .dest_select_high_i(req.dest_select[1]), .dest_select_low_i(req.dest_select[0]),
    .channel_address_i(req.channel_address), .write_word_bits_i(req.write_word_bits),
    .rd_chan_i(rd_chan), .rd_code_o(code), .rd_offset_o(offs), .rd_gain_o(gain),
    .reference_ground_level_o(gnd), .soft_reset_o(srst));

  // ************************************************************
  // Checking and readback
  // ************************************************************
  task automatic chk(input string nm, input logic [13:0] seen, input logic [13:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic rd(input int ch, input logic [13:0] c, input logic [13:0] o, input logic [13:0] g);
    @(negedge clk);
    rd_chan = ch[5:0];
    @(negedge clk);
    chk("code", code, c);
    chk("offset", offs, o);
    chk("gain", gain, g);
  endtask : rd

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : give_verdict

  // ************************************************************
  // Scenarios
  // ************************************************************
  initial begin
    repeat (12) @(negedge clk);
    nrst = 1'b1;
    rd(39, DWD_CODE_RST, DWD_OFFSET_RST, DWD_GAIN_RST);
    chk("ground", {13'h0, gnd}, 14'h0001);
    host_u.send(DWD_SEL_CODE, 8'h23, 14'h3ff0);
    rd(13, 14'h3ff0, DWD_OFFSET_RST, DWD_GAIN_RST);
    chk("ground", {13'h0, gnd}, 14'h0000);
    rd(3, DWD_CODE_RST, DWD_OFFSET_RST, DWD_GAIN_RST);
    host_u.send(DWD_SEL_GAIN, 8'h59, 14'h1555);
    host_u.send(DWD_SEL_OFFSET, 8'h59, 14'h0aaa);
    rd(9, DWD_CODE_RST, 14'h0aaa, 14'h1555);
    rd(29, DWD_CODE_RST, 14'h0aaa, 14'h1555);
    rd(19, DWD_CODE_RST, DWD_OFFSET_RST, DWD_GAIN_RST);
    host_u.send(DWD_SEL_CODE, 8'h8a, 14'h1234);
    rd(30, DWD_CODE_RST, DWD_OFFSET_RST, DWD_GAIN_RST);
    // Step mode on channel 13 saturating at full scale, then a broadcast step saturating at zero
    host_u.send(DWD_SEL_SPECIAL, 8'h23, 14'h017f);
    rd(13, 14'h3fff, DWD_OFFSET_RST, DWD_GAIN_RST);
    host_u.send(DWD_SEL_SPECIAL, 8'h23, 14'h0000);
    host_u.send(DWD_SEL_SPECIAL, 8'h23, 14'h0100);
    host_u.send(DWD_SEL_SPECIAL, 8'h23, 14'h0081);
    rd(13, 14'h3fff, DWD_OFFSET_RST, DWD_GAIN_RST);
    host_u.send(DWD_SEL_SPECIAL, 8'h23, 14'h0007);
    rd(13, 14'h3ff8, DWD_OFFSET_RST, DWD_GAIN_RST);
    host_u.send(DWD_SEL_CODE, 8'h0f, 14'h0003);
    rd(0, 14'h0003, DWD_OFFSET_RST, DWD_GAIN_RST);
    host_u.send(DWD_SEL_SPECIAL, 8'h00, 14'h007f);
    rd(39, DWD_ZERO_SCALE, DWD_OFFSET_RST, DWD_GAIN_RST);
    // Soft reset: one pulse, everything back to reset values
    host_u.send(DWD_SEL_SPECIAL, 8'h00, DWD_SOFT_RESET_WORD);
    pulses = 0;
    for (int i = 0; i < 4; i++) begin
      pulses += (srst === 1'b1);
      @(negedge clk);
    end
    chk("pulse", pulses[13:0], 14'h0001);
    chk("ground", {13'h0, gnd}, 14'h0001);
    rd(9, DWD_CODE_RST, DWD_OFFSET_RST, DWD_GAIN_RST);
    // Broadcast increment, then writes through other group masks
    host_u.send(DWD_SEL_SPECIAL, 8'h00, 14'h0105);
    host_u.send(DWD_SEL_GAIN, 8'h99, 14'h2222);
    rd(39, 14'h0005, DWD_OFFSET_RST, 14'h2222);
    rd(19, 14'h0005, DWD_OFFSET_RST, DWD_GAIN_RST);
    host_u.send(DWD_SEL_OFFSET, 8'h14, 14'h3001);
    rd(4, 14'h0005, 14'h3001, DWD_GAIN_RST);
    rd(45, 14'h0000, 14'h0000, 14'h0000);
    give_verdict();
  end

  // Cuts a hang short
  initial begin
    repeat (5000) @(posedge clk);
    fail_count++;
    give_verdict();
  end
endmodule : dwd_write_decode_bench
